// ---- rtl/dpr_pkg.sv ----
/*
 package for the dual-port memory port controller: pin timing counts,
 mailbox addresses, semaphore count and values, command and state encodings.
 assumes a 25 MHz clock and one memory port driven per controller.
*/
// Summary of operation
// [R1] memory is 4K words of 8 bits
// [R2] write is select low and read_write_n low
// [R3] read_write_n high while address lines change
// [R4] wait flow-through delay before reading new data
// [R5] read drives select and output enable low
// [R6] left write FFF sets right mailbox flag
// [R7] right write FFE sets left mailbox flag
// [R8] mailbox words are ordinary storage
// [R9] contention on equal address grants one port
// [R10] contention flag low while addresses match
// [R11] master drives contention flags, slave receives
// [R12] slave writes wait for settled contention flag
// [R13] eight semaphore latches beside the array
// [R14] semaphore select low, array select high
// [R15] semaphore write uses data bit 0 only
// [R16] writing 0 to free semaphore grants it
// [R17] owner writing 1 frees or hands over
// [R18] request by writing 0, read back, poll
// [R19] deselect for update pulse before read back
// [R20] semaphore read value latched in output register
// [R21] simultaneous semaphore request grants one side
// [R22] software writes 1 to all semaphores first
// [R23] flags start deasserted high after power-up
package dpr_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int SEM_COUNT = 8;
   localparam int CLK_PERIOD_NS = 40;
   // write pulse, minimum 20 ns
   localparam int WRITE_PULSE_NS = 20;
   localparam int WRITE_PULSE_CYC =
      (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // read access, address to data, 25 ns
   localparam int READ_ACCESS_NS = 25;
   localparam int READ_ACCESS_CYC =
      (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PORT_TO_PORT_FLOW_DELAY_NS = 30;
   localparam int PORT_TO_PORT_FLOW_DELAY_CYC =
      (PORT_TO_PORT_FLOW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEMAPHORE_UPDATE_PULSE_NS = 10;
   localparam int SEMAPHORE_UPDATE_PULSE_CYC =
      (SEMAPHORE_UPDATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // contention flag settle, 20 ns
   localparam int CONTENTION_SETTLE_NS = 20;
   localparam int CONTENTION_SETTLE_CYC =
      (CONTENTION_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [ADDR_W-1:0] MAILBOX_TO_RIGHT = 12'hFFF;
   localparam logic [ADDR_W-1:0] MAILBOX_TO_LEFT = 12'hFFE;
   localparam logic [DATA_W-1:0] SEM_REQUEST = 8'h00;
   localparam logic [DATA_W-1:0] SEM_RELEASE = 8'h01;
   typedef enum logic [1:0] {
      DPR_CMD_MEM_READ = 2'b00,
      DPR_CMD_MEM_WRITE = 2'b01,
      DPR_CMD_SEM_READ = 2'b10,
      DPR_CMD_SEM_WRITE = 2'b11
   } dpr_cmd_type;
   typedef enum logic [2:0] {
      DPR_IDLE = 3'b000,
      DPR_SETUP = 3'b001,
      DPR_WAIT_FREE = 3'b010,
      DPR_STROBE = 3'b011,
      DPR_RECOVER = 3'b100
   } dpr_state_type;
endpackage

// ---- rtl/dpr_port_ctrl.sv ----
/*
 controller for one port of the dual-port memory with mailbox flags,
 contention flags and semaphores. a user request on the command side
 becomes a timed pin sequence; read data returns with a done pulse.
 after reset it frees all eight semaphores before taking requests.
 assumes pin inputs synchronous to clk and a device outside the chip.
*/
`timescale 1ns/1ps
`default_nettype none
module dpr_port_ctrl (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic req,
   input wire dpr_pkg::dpr_cmd_type cmd,
   input wire logic [dpr_pkg::ADDR_W-1:0] addr,
   input wire logic [dpr_pkg::DATA_W-1:0] wdata,
   input wire logic slave_mode,
   output logic busy,
   output logic done,
   output logic [dpr_pkg::DATA_W-1:0] rdata,
   output logic sem_owned,
   output logic mailbox_pending,
   output logic [dpr_pkg::ADDR_W-1:0] mem_addr,
   output logic array_sel_n,
   output logic sem_sel_n,
   output logic read_write_n,
   output logic output_drive_enable_n,
   output logic [dpr_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [dpr_pkg::DATA_W-1:0] data_in,
   input wire logic contention_n,
   input wire logic mailbox_n
);
   import dpr_pkg::*;
   typedef struct packed {
      dpr_state_type state;
      dpr_cmd_type cmd;
      logic [CNT_W-1:0] cnt;
      logic busy;
      logic done;
      logic [DATA_W-1:0] rdata;
      logic sem_owned;
      logic mailbox_pending;
      logic [ADDR_W-1:0] mem_addr;
      logic array_sel_n;
      logic sem_sel_n;
      logic read_write_n;
      logic output_drive_enable_n;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
      logic init_run;
      logic [2:0] init_idx;
   } dpr_regs_type;
   localparam logic [2:0] LAST_SEM = 3'(SEM_COUNT - 1);
   dpr_regs_type r;
   dpr_regs_type next_r;
   logic is_write;
   logic is_sem;
   logic init_last;
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.mailbox_pending = ~mailbox_n;
      is_write = (r.cmd == DPR_CMD_MEM_WRITE) ||
         (r.cmd == DPR_CMD_SEM_WRITE);
      is_sem = r.cmd[1];
      init_last = (r.init_idx == LAST_SEM);
      unique case (r.state)
         DPR_IDLE: begin
            if (r.init_run) begin
               // free one semaphore per pass after reset [R22]
               next_r.cmd = DPR_CMD_SEM_WRITE;
               next_r.busy = 1'b1;
               next_r.read_write_n = 1'b1;
               next_r.mem_addr = {{(ADDR_W-3){1'b0}}, r.init_idx};
               next_r.data_out = {DATA_W{SEM_RELEASE[0]}};
               next_r.cnt = CNT_W'(CONTENTION_SETTLE_CYC);
               next_r.state = DPR_SETUP;
            end else if (req) begin
               next_r.cmd = cmd;
               next_r.busy = 1'b1;
               // address moves only with read_write_n high [R3]
               next_r.read_write_n = 1'b1;
               if (cmd[1]) begin
                  // latch index on low bits, rest zero [R14]
                  next_r.mem_addr = {{(ADDR_W-3){1'b0}}, addr[2:0]};
                  // only bit 0 matters, repeat it across the byte [R15]
                  next_r.data_out = {DATA_W{wdata[0]}};
               end else begin
                  next_r.mem_addr = addr;
                  next_r.data_out = wdata;
               end
               next_r.cnt = CNT_W'(CONTENTION_SETTLE_CYC);
               next_r.state = DPR_SETUP;
            end
         end
         DPR_SETUP: begin
            // select the target: array or semaphore, never both [R5] [R14]
            next_r.array_sel_n = is_sem;
            next_r.sem_sel_n = ~is_sem;
            if (!is_write) begin
               next_r.output_drive_enable_n = 1'b0;
            end
            // let contention flag settle before a write [R12]
            if (r.cnt != '0) begin
               next_r.cnt = r.cnt - 1'b1;
            end else begin
               next_r.state = DPR_WAIT_FREE;
            end
         end
         DPR_WAIT_FREE: begin
            // hold off while this port loses arbitration [R9] [R10] [R12]
            if (is_sem || contention_n) begin
               if (is_write) begin
                  // write pulse: select low with read_write_n low [R2]
                  next_r.read_write_n = 1'b0;
                  next_r.data_oe = 1'b1;
                  next_r.cnt = CNT_W'(WRITE_PULSE_CYC);
               end else begin
                  // wait access plus flow-through before sampling [R4]
                  next_r.cnt = CNT_W'(READ_ACCESS_CYC +
                     PORT_TO_PORT_FLOW_DELAY_CYC);
               end
               next_r.state = DPR_STROBE;
            end
         end
         DPR_STROBE: begin
            if (r.cnt != '0) begin
               next_r.cnt = r.cnt - 1'b1;
            end else begin
               if (is_write) begin
                  // read_write_n rises first and ends the write [R2]
                  next_r.read_write_n = 1'b1;
               end else begin
                  next_r.rdata = data_in;
                  if (is_sem) begin
                     // value 0 read back means this port owns it [R18]
                     next_r.sem_owned = ~data_in[0];
                  end
               end
               next_r.cnt = CNT_W'(SEMAPHORE_UPDATE_PULSE_CYC);
               next_r.state = DPR_RECOVER;
            end
         end
         DPR_RECOVER: begin
            // deselect for the update pulse before next access [R19]
            next_r.array_sel_n = 1'b1;
            next_r.sem_sel_n = 1'b1;
            next_r.output_drive_enable_n = 1'b1;
            next_r.data_oe = 1'b0;
            if (r.cnt != '0) begin
               next_r.cnt = r.cnt - 1'b1;
            end else begin
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
               next_r.state = DPR_IDLE;
               if (r.init_run) begin
                  // power-up pass stays busy unless it is the last, and gives no done [R22]
                  next_r.busy = ~init_last;
                  next_r.done = 1'b0;
                  next_r.init_idx = r.init_idx + 1'b1;
                  next_r.init_run = ~init_last;
               end
            end
         end
         default: begin
            next_r.state = DPR_IDLE;
         end
      endcase
      if (!slave_mode && r.state == DPR_IDLE && !r.init_run) begin
         next_r.busy = req;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r.state <= DPR_IDLE;
         r.cmd <= DPR_CMD_MEM_READ;
         r.cnt <= '0;
         r.busy <= 1'b0;
         r.done <= 1'b0;
         r.rdata <= '0;
         r.sem_owned <= 1'b0;
         r.mailbox_pending <= 1'b0;
         r.mem_addr <= '0;
         r.array_sel_n <= 1'b1;
         r.sem_sel_n <= 1'b1;
         r.read_write_n <= 1'b1;
         r.output_drive_enable_n <= 1'b1;
         r.data_out <= '0;
         r.data_oe <= 1'b0;
         r.init_run <= 1'b1;
         r.init_idx <= 3'h0;
      end else begin
         r <= next_r;
      end
   end
   assign busy = r.busy;
   assign done = r.done;
   assign rdata = r.rdata;
   assign sem_owned = r.sem_owned;
   assign mailbox_pending = r.mailbox_pending;
   assign mem_addr = r.mem_addr;
   assign array_sel_n = r.array_sel_n;
   assign sem_sel_n = r.sem_sel_n;
   assign read_write_n = r.read_write_n;
   assign output_drive_enable_n = r.output_drive_enable_n;
   assign data_out = r.data_out;
   assign data_oe = r.data_oe;
endmodule
`default_nettype wire

// ---- verification/dpr_monitor.sv ----
/* pin checker for one memory port controller.
   bound to dpr_port_ctrl; sees its pins only. */
`timescale 1ns/1ps
`default_nettype none
module dpr_monitor (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [11:0] mem_addr,
   input wire logic array_sel_n,
   input wire logic sem_sel_n,
   input wire logic read_write_n,
   input wire logic output_drive_enable_n,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic contention_n
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   a_sel_excl: assert property (array_sel_n || sem_sel_n)
      else $error("both selects low");
   a_addr_stable: assert property ($changed(mem_addr) |->
      read_write_n && $past(read_write_n)) else $error("address moved");
   a_write_sel: assert property (!read_write_n |->
      !(array_sel_n && sem_sel_n)) else $error("write unselected");
   a_pulse_len: assert property ($fell(read_write_n) |->
      !read_write_n [*2]) else $error("short write");
   a_write_drive: assert property ($fell(read_write_n) |-> data_oe)
      else $error("write data not driven");
   a_read_dir: assert property (
      !output_drive_enable_n |-> read_write_n)
      else $error("output enable in write");
   a_sem_bit0: assert property (!sem_sel_n && !read_write_n |->
      data_out == {8{data_out[0]}}) else $error("sem data");
   a_cont_wait: assert property (
      $fell(read_write_n) && !array_sel_n |-> $past(contention_n))
      else $error("write in contention");
   a_sem_gap: assert property ($rose(sem_sel_n) |-> sem_sel_n [*2])
      else $error("short semaphore deselect");
   a_sem_addr: assert property (!sem_sel_n |-> mem_addr[11:3] == 9'h000)
      else $error("sem upper address");
endmodule
bind dpr_port_ctrl dpr_monitor dpr_monitor_i (
   .clk(clk),
   .arst_n(arst_n),
   .mem_addr(mem_addr),
   .array_sel_n(array_sel_n),
   .sem_sel_n(sem_sel_n),
   .read_write_n(read_write_n),
   .output_drive_enable_n(output_drive_enable_n),
   .data_out(data_out),
   .data_oe(data_oe),
   .contention_n(contention_n)
);
`default_nettype wire

// ---- verification/dpr_device.sv ----
/* device model: array, mailbox flags, semaphores, contention.
   left port is the controller; right port acts through tasks. */
`timescale 1ns/1ps
`default_nettype none
module dpr_device (
   input wire logic [11:0] mem_addr,
   input wire logic array_sel_n,
   input wire logic sem_sel_n,
   input wire logic read_write_n,
   input wire logic output_drive_enable_n,
   input wire logic [7:0] data_out,
   output logic [7:0] data_in,
   output logic contention_n,
   output logic mailbox_n
);
   import dpr_pkg::*;
   logic [7:0] mem [4096];
   logic [7:0] lreq, rreq, own, q = 8'h00;
   logic wa = 0, ws = 0, rsel = 0, mb_r = 1;
   logic [11:0] raddr = 12'h000;
   wire rd = read_write_n && !output_drive_enable_n
      && !(array_sel_n && sem_sel_n);
   initial mailbox_n = 1;
   assign contention_n =
      !(rsel && !array_sel_n && raddr == mem_addr);
   assign data_in = rd ? q : ~q;
   always @* begin
      if (!read_write_n) begin
         wa = !array_sel_n;
         ws = !sem_sel_n;
      end
   end
   task automatic sem_wr(input logic rt, input logic [2:0] i, input logic v);
      if (rt) rreq[i] = !v;
      else lreq[i] = !v;
      if (v) own[i] = !rt;
      else if (!(rt ? lreq[i] : rreq[i])) own[i] = rt;
   endtask
   always @(posedge read_write_n) begin
      if (wa) begin
         mem[mem_addr] = data_out;
         if (mem_addr == MAILBOX_TO_RIGHT) mb_r = 0;
      end else if (ws) sem_wr(0, mem_addr[2:0], data_out[0]);
   end
   always @(posedge rd) begin
      #1;
      if (!array_sel_n) q = mem[mem_addr];
      else q = {8{!(lreq[mem_addr[2:0]] && !own[mem_addr[2:0]])}};
      if (!array_sel_n && mem_addr == MAILBOX_TO_LEFT) mailbox_n = 1;
   end
   task automatic right_wr(input logic [11:0] a, input logic [7:0] d);
      mem[a] = d;
      if (a == MAILBOX_TO_LEFT) mailbox_n = 0;
   endtask
   task automatic right_rd(input logic [11:0] a, output logic [7:0] d);
      d = mem[a];
      if (a == MAILBOX_TO_RIGHT) mb_r = 1;
   endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
/* bench for the port controller against the device model.
   assumes the monitor binds itself to the controller. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpr_pkg::*;
   logic clk = 0, arst_n = 0, req = 0, slave_mode = 0;
   dpr_cmd_type cmd = DPR_CMD_MEM_READ;
   logic [11:0] addr = 12'h000, mem_addr;
   logic [7:0] wdata = 8'h00, rdata, data_out, data_in, d;
   logic busy, done, sem_owned, mailbox_pending, array_sel_n, sem_sel_n;
   logic read_write_n, output_drive_enable_n, data_oe, contention_n, mailbox_n;
   int errors = 0, check_count = 0;
   always #20 clk = ~clk;
   dpr_port_ctrl dpr_port_ctrl_i (
      .clk(clk),
      .arst_n(arst_n),
      .req(req),
      .cmd(cmd),
      .addr(addr),
      .wdata(wdata),
      .slave_mode(slave_mode),
      .busy(busy),
      .done(done),
      .rdata(rdata),
      .sem_owned(sem_owned),
      .mailbox_pending(mailbox_pending),
      .mem_addr(mem_addr),
      .array_sel_n(array_sel_n),
      .sem_sel_n(sem_sel_n),
      .read_write_n(read_write_n),
      .output_drive_enable_n(output_drive_enable_n),
      .data_out(data_out),
      .data_oe(data_oe),
      .data_in(data_in),
      .contention_n(contention_n),
      .mailbox_n(mailbox_n)
   );
   dpr_device dpr_device_i (
      .mem_addr(mem_addr),
      .array_sel_n(array_sel_n),
      .sem_sel_n(sem_sel_n),
      .read_write_n(read_write_n),
      .output_drive_enable_n(output_drive_enable_n),
      .data_out(data_out),
      .data_in(data_in),
      .contention_n(contention_n),
      .mailbox_n(mailbox_n)
   );
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic go(input dpr_cmd_type c, input logic [11:0] a,
         input logic [7:0] w);
      @(negedge clk);
      cmd = c;
      addr = a;
      wdata = w;
      req = 1;
      @(negedge clk);
      req = 0;
   endtask
   task automatic fin;
      int n = 0;
      while (done !== 1'b1) begin
         n++;
         if (n > 300) begin
            errors++;
            report_and_stop;
         end
         @(posedge clk);
         #1;
      end
   endtask
   task automatic acc(input dpr_cmd_type c, input logic [11:0] a,
         input logic [7:0] w);
      go(c, a, w);
      fin;
   endtask
   task automatic t_init;
      int n = 0;
      repeat (2) @(posedge clk);
      #1;
      chk(busy, 8'h01);
      while (busy !== 1'b0) begin
         n++;
         if (n > 300) begin
            errors++;
            report_and_stop;
         end
         @(posedge clk);
         #1;
      end
      for (int i = 0; i < 8; i++) begin
         acc(DPR_CMD_SEM_READ, 12'(i), 8'h00);
         chk(rdata, 8'hFF);
      end
      $display("init test over");
   endtask
   task automatic t_mem;
      for (int i = 0; i < 3; i++) begin
         acc(DPR_CMD_MEM_WRITE, {i[1:0], 10'h3FF}, {i[3:0], 4'hA});
      end
      for (int i = 0; i < 3; i++) begin
         acc(DPR_CMD_MEM_READ, {i[1:0], 10'h3FF}, 8'h00);
         chk(rdata, {i[3:0], 4'hA});
      end
      $display("mem test over");
   endtask
   task automatic t_mbox;
      acc(DPR_CMD_MEM_WRITE, MAILBOX_TO_RIGHT, 8'h3C);
      chk(dpr_device_i.mb_r, 8'h00);
      dpr_device_i.right_rd(MAILBOX_TO_RIGHT, d);
      chk(d, 8'h3C);
      chk(dpr_device_i.mb_r, 8'h01);
      @(negedge clk);
      dpr_device_i.right_wr(MAILBOX_TO_LEFT, 8'hC3);
      repeat (3) @(negedge clk);
      chk(mailbox_pending, 8'h01);
      acc(DPR_CMD_MEM_READ, MAILBOX_TO_LEFT, 8'h00);
      chk(rdata, 8'hC3);
      repeat (3) @(negedge clk);
      chk(mailbox_pending, 8'h00);
      $display("mailbox test over");
   endtask
   task automatic t_sem;
      for (int i = 0; i < 8; i++) begin
         acc(DPR_CMD_SEM_WRITE, 12'(i), SEM_RELEASE);
         dpr_device_i.sem_wr(1'b1, 3'(i), 1'b1);
      end
      acc(DPR_CMD_SEM_WRITE, 12'hFF3, 8'hFE);
      acc(DPR_CMD_SEM_READ, 12'hFF3, 8'h00);
      chk(rdata, 8'h00);
      chk(sem_owned, 8'h01);
      dpr_device_i.sem_wr(1'b1, 3'h3, 1'b0);
      acc(DPR_CMD_SEM_WRITE, 12'h003, SEM_RELEASE);
      acc(DPR_CMD_SEM_READ, 12'h003, 8'h00);
      chk(rdata, 8'hFF);
      chk(sem_owned, 8'h00);
      acc(DPR_CMD_SEM_WRITE, 12'h003, SEM_REQUEST);
      dpr_device_i.sem_wr(1'b1, 3'h3, 1'b1);
      acc(DPR_CMD_SEM_READ, 12'h003, 8'h00);
      chk(rdata, 8'h00);
      $display("semaphore test over");
   endtask
   task automatic t_cont;
      @(negedge clk);
      slave_mode = 1'b1;
      dpr_device_i.raddr = 12'h123;
      dpr_device_i.rsel = 1'b1;
      go(DPR_CMD_MEM_WRITE, 12'h123, 8'h77);
      repeat (20) @(negedge clk);
      chk(busy, 8'h01);
      chk(read_write_n, 8'h01);
      dpr_device_i.rsel = 1'b0;
      fin;
      chk(dpr_device_i.mem[12'h123], 8'h77);
      @(negedge clk);
      slave_mode = 1'b0;
      $display("contention test over");
   endtask
   initial begin
      repeat (10) @(negedge clk);
      arst_n = 1;
      t_init;
      t_mem;
      t_mbox;
      t_sem;
      t_cont;
      report_and_stop;
   end
endmodule
`default_nettype wire
